//--- logic/arbi_defines.svh
/*
 constants for the result bus interface of the integrating converter.
 assumes inclusion by bare name from logic/ sources.
*/
`ifndef ARBI_DEFINES_SVH
`define ARBI_DEFINES_SVH
`define ARBI_DIV_COUNT      2'h3
`define ARBI_ZERO_CYCLES    10'h0f6
`define ARBI_SIGNAL_CYCLES  10'h100
`define ARBI_DEINT_CYCLES   10'h30a
`define ARBI_RESULT_W       16
`define ARBI_SEL_RESET      1'h0
`define ARBI_HIGH_RESET     1'h1
`define ARBI_SYNC_RESET     7'h7c
`endif

//--- logic/arbi_pkg.sv
/*
 types for the result bus interface.
 assumes nothing of its surroundings.
*/
`default_nettype none
package arbi_pkg;
	typedef enum logic [1:0] {ARBI_IDLE, ARBI_ZERO, ARBI_SIGNAL, ARBI_DEINT} arbi_phase_t;
	typedef enum logic [1:0] {ARBI_BYTE_LOW, ARBI_BYTE_HIGH, ARBI_BYTE_FLAGS} arbi_byte_t;
endpackage : arbi_pkg
`default_nettype wire

//--- logic/arbi_result_store.sv
/*
 result latch: holds the finished conversion word, read data from a register.
 assumes one clock domain shared with the top.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arbi_defines.svh"
module arbi_result_store
(
	input  wire logic                      clk_i,
	input  wire logic                      rst_n_i,
	input  wire logic                      wr_en_i,
	input  wire logic [`ARBI_RESULT_W-1:0] wr_data_i,
	input  wire logic                      wr_ovr_i,
	output logic      [`ARBI_RESULT_W-1:0] rd_data_o,
	output logic                           rd_ovr_o
);
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			rd_data_o <= '0;
			rd_ovr_o  <= 1'h0;
		end
		else if (wr_en_i)
		begin
			rd_data_o <= wr_data_i;
			rd_ovr_o  <= wr_ovr_i;
		end
	end
endmodule : arbi_result_store
`default_nettype wire

//--- logic/arbi_top.sv
/*
 host-side digital interface of the integrating converter: selects, strobes,
 byte steering, busy flag and conversion phase sequencing.
 assumes pin inputs asynchronous; result magnitude, sign and overrange come
 from the analog section through plain inputs.
*/
`timescale 1ns/1ps
`default_nettype none
`include "arbi_defines.svh"
module arbi_top
(
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_N_I,
	input  wire logic        CHIP_SEL_I,
	input  wire logic        CHIP_EN_N_I,
	input  wire logic        CONVERT_N_I,
	input  wire logic        READ_N_I,
	input  wire logic        RUN_CONT_I,
	input  wire logic        SIGN_FLAG_SELECT_I,
	input  wire logic        BYTE_SEL_LOW_I,
	input  wire logic [14:0] MAG_I,
	input  wire logic        POL_I,
	input  wire logic        OVR_I,
	output logic      [7:0]  DATA_O,
	output logic      [7:0]  DATA_OE_O,
	output logic             BUSY_O
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; floating pins resolved by pad pulls outside
	logic [6:0] sync1;
	logic [6:0] sync2;
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			sync1 <= `ARBI_SYNC_RESET;
			sync2 <= `ARBI_SYNC_RESET;
		end
		else
		begin
			sync1 <= {SIGN_FLAG_SELECT_I, BYTE_SEL_LOW_I, READ_N_I, CONVERT_N_I, CHIP_EN_N_I, RUN_CONT_I, CHIP_SEL_I};
			sync2 <= sync1;
		end
	end
	logic sel;
	logic cont;
	logic rd_n;
	logic wr_n;
	logic byte_low;
	logic sflag;
	assign sel      = sync2[0] & ~sync2[2];
	assign cont     = sync2[1];
	assign wr_n     = sync2[3];
	assign rd_n     = sync2[4];
	assign byte_low = sync2[5];
	assign sflag    = sync2[6];

	////////////////////////////////////////////////////////////////////////////
	// divide by four tick for conversion counters
	logic [1:0] div;
	logic       tick;
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
			div <= 2'h0;
		else
			div <= div + 2'h1;
	end
	assign tick = (div == `ARBI_DIV_COUNT);

	////////////////////////////////////////////////////////////////////////////
	// conversion phases
	arbi_pkg::arbi_phase_t phase;
	logic [9:0]            cnt;
	logic                  start_req;
	logic                  done;
	logic                  wr_seen;
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
			wr_seen <= 1'h0;
		else if (!cont && sel && !wr_n)
			wr_seen <= 1'h1;
		else if (phase == arbi_pkg::ARBI_ZERO)
			wr_seen <= 1'h0;
	end
	assign start_req = cont | wr_seen;
	assign done      = tick && phase == arbi_pkg::ARBI_DEINT && cnt == `ARBI_DEINT_CYCLES - 10'h1;
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			phase <= arbi_pkg::ARBI_IDLE;
			cnt   <= 10'h0;
		end
		else if (tick)
		begin
			cnt <= cnt + 10'h1;
			unique case (phase)
				arbi_pkg::ARBI_IDLE:
				begin
					cnt <= 10'h0;
					if (start_req)
						phase <= arbi_pkg::ARBI_ZERO;
				end
				arbi_pkg::ARBI_ZERO:
					if (cnt == `ARBI_ZERO_CYCLES - 10'h1)
					begin
						cnt   <= 10'h0;
						phase <= arbi_pkg::ARBI_SIGNAL;
					end
				arbi_pkg::ARBI_SIGNAL:
					if (cnt == `ARBI_SIGNAL_CYCLES - 10'h1)
					begin
						cnt   <= 10'h0;
						phase <= arbi_pkg::ARBI_DEINT;
					end
				arbi_pkg::ARBI_DEINT:
					if (cnt == `ARBI_DEINT_CYCLES - 10'h1)
					begin
						cnt   <= 10'h0;
						phase <= cont ? arbi_pkg::ARBI_ZERO : arbi_pkg::ARBI_IDLE;
					end
			endcase
		end
	end
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
			BUSY_O <= 1'h0;
		else if (done)
			BUSY_O <= 1'h0;
		else if (tick && phase == arbi_pkg::ARBI_SIGNAL && cnt == `ARBI_SIGNAL_CYCLES - 10'h1)
			BUSY_O <= 1'h1;
	end

	////////////////////////////////////////////////////////////////////////////
	// result latch
	logic [15:0] res;
	logic        res_ovr;
	arbi_result_store u_store
	(
		.clk_i     (CLK_SYS_I),
		.rst_n_i   (RST_N_I),
		.wr_en_i   (done),
		.wr_data_i ({POL_I, MAG_I}),
		.wr_ovr_i  (OVR_I),
		.rd_data_o (res),
		.rd_ovr_o  (res_ovr)
	);

	////////////////////////////////////////////////////////////////////////////
	// continuous mode byte sequencer
	arbi_pkg::arbi_byte_t seq;
	logic                 rd_prev;
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
			rd_prev <= 1'h1;
		else
			rd_prev <= rd_n;
	end
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I || !cont)
			seq <= arbi_pkg::ARBI_BYTE_LOW;
		else if (sel && rd_n && !rd_prev)
		begin
			unique case (seq)
				arbi_pkg::ARBI_BYTE_LOW:   seq <= arbi_pkg::ARBI_BYTE_HIGH;
				arbi_pkg::ARBI_BYTE_HIGH:  seq <= arbi_pkg::ARBI_BYTE_FLAGS;
				arbi_pkg::ARBI_BYTE_FLAGS: seq <= arbi_pkg::ARBI_BYTE_LOW;
				default:                   seq <= arbi_pkg::ARBI_BYTE_LOW;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// data steering and drive
	logic [7:0] next_data;
	always_comb
	begin
		if (cont)
		begin
			unique case (seq)
				arbi_pkg::ARBI_BYTE_LOW:   next_data = res[7:0];
				arbi_pkg::ARBI_BYTE_HIGH:  next_data = {1'h0, res[14:8]};
				default:                   next_data = {res[15], res_ovr, 6'h0};
			endcase
		end
		else if (byte_low)
			next_data = res[7:0];
		else
			next_data = {sflag ? res_ovr : res[15], res[14:8]};
	end
	always_ff @(posedge CLK_SYS_I)
	begin
		if (!RST_N_I)
		begin
			DATA_O    <= 8'h00;
			DATA_OE_O <= 8'h00;
		end
		else
		begin
			DATA_O    <= next_data;
			DATA_OE_O <= {8{sel & ~rd_n}};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	drive_gate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		DATA_OE_O[0] |-> $past(sel) && !$past(rd_n))
		else $error("data driven while not selected for read");
	sel_and_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!sync2[0] |-> !sel)
		else $error("select honoured while chip select low");
	conv_gate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		$rose(wr_seen) |-> $past(sync2[0]) && !$past(sync2[2]) && !$past(cont))
		else $error("convert taken while not selected");
	flag_line_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!cont && !byte_low && sflag |=> DATA_O[7] == $past(res_ovr))
		else $error("overrange not on top data line");
	busy_rise_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		$rose(BUSY_O) |-> phase == arbi_pkg::ARBI_DEINT && cnt == 10'h0)
		else $error("busy rose outside deintegrate start");
	busy_fall_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		done |=> !BUSY_O)
		else $error("busy not low after completion");
	idle_quiet_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		phase == arbi_pkg::ARBI_IDLE |-> !BUSY_O)
		else $error("busy high while idle");
	tick_rate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
		else $error("counter tick not every fourth clock");
	cont_run_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		cont && phase == arbi_pkg::ARBI_IDLE && tick |=> phase == arbi_pkg::ARBI_ZERO)
		else $error("continuous mode did not start");
	seq_wrap_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		$past(cont) && cont && $past(seq) == arbi_pkg::ARBI_BYTE_FLAGS && $changed(seq)
		|-> seq == arbi_pkg::ARBI_BYTE_LOW)
		else $error("byte sequence did not wrap");
	byte_pick_a: assert property (@(posedge CLK_SYS_I) disable iff (!RST_N_I)
		!cont && byte_low && $stable(res) |=> DATA_O == $past(res[7:0]))
		else $error("low byte not presented");
endmodule : arbi_top
`default_nettype wire

//--- tb/arbi_host.sv
/*
 host processor model: drives selects and strobes of the result bus.
 assumes tb_top owns the clock and calls the tasks.
*/
`timescale 1ns/1ps
`default_nettype none
module arbi_host
(
	input  wire logic       clk_i,
	input  wire logic [7:0] data_i,
	input  wire logic [7:0] oe_i,
	output logic            sel_o,
	output logic            en_n_o,
	output logic            conv_n_o,
	output logic            rd_n_o,
	output logic            run_o,
	output logic            flag_sel_o,
	output logic            low_o
);
initial
begin
	sel_o = 1'h0;
	en_n_o = 1'h0;
	conv_n_o = 1'h1;
	rd_n_o = 1'h1;
	run_o = 1'h0;
	flag_sel_o = 1'h0;
	low_o = 1'h1;
end
////////////////////////////////////////////////////////////////
// select, enable and run-mode levels, changed just after an edge
task mode(input logic s, input logic e, input logic r);
	@(posedge clk_i);
	sel_o <= s;
	en_n_o <= e;
	run_o <= r;
endtask : mode
// convert strobe held four cycles
task conv;
	@(posedge clk_i);
	conv_n_o <= 1'h0;
	repeat (4) @(posedge clk_i);
	conv_n_o <= 1'h1;
endtask : conv
// one read cycle, selects held through the strobe
task rd(input logic low, input logic fsel, output logic [7:0] d, output logic [7:0] oe);
	@(posedge clk_i);
	low_o <= low;
	flag_sel_o <= fsel;
	rd_n_o <= 1'h0;
	repeat (5) @(posedge clk_i);
	#1;
	d = data_i;
	oe = oe_i;
	@(posedge clk_i);
	rd_n_o <= 1'h1;
	repeat (5) @(posedge clk_i);
endtask : rd
endmodule : arbi_host
`default_nettype wire

//--- tb/tb_top.sv
/*
 bench for the result bus interface: host model plus analog stand-in.
 assumes the design files under logic/.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
logic        clk;
logic        rst_n;
logic [14:0] mag;
logic        pol;
logic        ovr;
logic        sel, en_n, cv_n, rd_n, run, fsel, low;
logic [7:0]  data, oe, d, o;
logic        busy;
int          fail_count, n_checks, cyc, len;
arbi_top dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .CHIP_SEL_I(sel), .CHIP_EN_N_I(en_n),
	.CONVERT_N_I(cv_n), .READ_N_I(rd_n), .RUN_CONT_I(run), .SIGN_FLAG_SELECT_I(fsel),
	.BYTE_SEL_LOW_I(low), .MAG_I(mag), .POL_I(pol), .OVR_I(ovr), .DATA_O(data),
	.DATA_OE_O(oe), .BUSY_O(busy));
arbi_host host (.clk_i(clk), .data_i(data), .oe_i(oe), .sel_o(sel), .en_n_o(en_n),
	.conv_n_o(cv_n), .rd_n_o(rd_n), .run_o(run), .flag_sel_o(fsel), .low_o(low));
initial
begin
	clk = 1'h0;
	forever #50 clk = ~clk;
end
////////////////////////////////////////////////////////////////
task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
	n_checks++;
	if (seen !== exp)
	begin
		$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		fail_count++;
	end
endtask : chk
task complete_run;
	$display("checks %0d mismatches %0d", n_checks, fail_count);
	if (fail_count == 0 && n_checks > 0)
		$display("verification passed");
	else
		$display("verification failed");
	$finish;
endtask : complete_run
// wait bounded for busy level, cycles waited in len
task busy_to(input logic lvl, input int lim);
	len = 0;
	while (busy !== lvl && len < lim)
	begin
		@(posedge clk);
		len++;
	end
	chk("busy", {7'h0, busy}, {7'h0, lvl});
endtask : busy_to
task rdc(input string nm, input logic l, input logic f, input logic [7:0] exp);
	host.rd(l, f, d, o);
	chk(nm, d, exp);
	chk("oe", o, 8'hff);
endtask : rdc
always @(posedge clk)
begin
	cyc++;
	if (cyc == 40000)
	begin
		fail_count++;
		complete_run();
	end
end
////////////////////////////////////////////////////////////////
initial
begin
	rst_n = 1'h0;
	mag = 15'h5a3c;
	pol = 1'h1;
	ovr = 1'h0;
	repeat (2) @(posedge clk);
	rst_n <= 1'h1;
	repeat (10) @(posedge clk);
	chk("idle busy", {7'h0, busy}, 8'h00);
	host.rd(1'h1, 1'h0, d, o);
	chk("oe unselected", o, 8'h00);
	host.conv();
	host.mode(1'h1, 1'h1, 1'h0);
	host.rd(1'h1, 1'h0, d, o);
	chk("oe disabled", o, 8'h00);
	host.conv();
	repeat (2300) @(posedge clk);
	chk("busy unselected", {7'h0, busy}, 8'h00);
	$display("test unselected done");
	host.mode(1'h1, 1'h0, 1'h0);
	host.conv();
	busy_to(1'h1, 2300);
	busy_to(1'h0, 3300);
	chk("deint length", {7'h0, len >= 3108 && len <= 3116}, 8'h01);
	rdc("low byte", 1'h1, 1'h0, 8'h3c);
	rdc("high polarity", 1'h0, 1'h0, 8'hda);
	rdc("high overrange", 1'h0, 1'h1, 8'h5a);
	repeat (4) @(posedge clk);
	chk("oe released", oe, 8'h00);
	$display("test demand done");
	mag <= 15'h1234;
	pol <= 1'h0;
	ovr <= 1'h1;
	host.mode(1'h1, 1'h0, 1'h1);
	busy_to(1'h1, 2300);
	busy_to(1'h0, 3300);
	rdc("cont first", 1'h1, 1'h0, 8'h34);
	rdc("cont second", 1'h1, 1'h0, 8'h12);
	rdc("cont third", 1'h1, 1'h0, 8'h40);
	rdc("cont wrap", 1'h1, 1'h0, 8'h34);
	busy_to(1'h1, 5300);
	$display("test continuous done");
	complete_run();
end
endmodule : tb_top
`default_nettype wire
